// ===== src/clutch_consts.svh
// How it works
// - Enabled axis starts released after init until an engage trigger is seen.
// - Disabled axis stays coupled; slave speed follows master directly.
// - Engage trigger is the engage request, detected by level, rise or fall.
// - Engage method is direct or slip; slip uses the engage slip time.
// - Release trigger is the release request alone, or request then phase wait.
// - Release detection is invalid, rising edge or falling edge.
// - Release method is direct or slip; slip uses the release slip time.
// - Phase release keeps slave running until phase reaches the set ratio.
// - Eight axes each have engage and release inputs and a coupled notify.
// - Level engage mode switches the clutch from the engage request only.
// - Level engage mode ignores release edge setting and release request.
// - Rising mode couples and releases on low-to-high request transitions.
// - Falling mode couples and releases on high-to-low request transitions.
// - Direct method steps slave speed to master or zero at once.
// - Slip method ramps slave speed linearly over the configured slip time.
// - Release phase ratio takes whole percent values zero to ninety-nine.
// - Trigger seen past the ratio waits for the next time phase reaches it.
`ifndef CLUTCH_CONSTS_SVH
`define CLUTCH_CONSTS_SVH

`define AXIS_COUNT        8
`define SPEED_W           16
`define PHASE_W           7
`define SLIP_W            8

`define OFS_CTRL          12'h000
`define OFS_STATUS        12'h004
`define OFS_AXIS_CFG0     12'h020
`define OFS_AXIS_CFG_LAST 12'h03C

`define CTRL_ENABLE_LSB   0
`define STATUS_COUPLED_LSB 0
`define STATUS_WAIT_LSB   8

`define CTRL_RESET        8'h00
`define AXIS_CFG_RESET    32'h0000_0000
`define PHASE_RATIO_MAX   7'h63

`endif

// ===== src/clutch_pkg.sv
package clutch_pkg;

	typedef enum logic [1:0]
	{
		EDGE_LEVEL = 2'b00,
		EDGE_RISE  = 2'b01,
		EDGE_FALL  = 2'b10
	} edge_sel_e;

	typedef enum logic [1:0]
	{
		AXIS_RELEASED   = 2'b00,
		AXIS_COUPLED    = 2'b01,
		AXIS_PHASE_WAIT = 2'b10
	} axis_state_e;

	typedef struct packed
	{
		logic [7:0]      release_slip;
		logic [7:0]      engage_slip;
		logic [1:0]      spare;
		logic [6:0]      phase_ratio;
		logic            release_slip_sel;
		edge_sel_e       release_edge;
		logic            release_phase_sel;
		logic            engage_slip_sel;
		edge_sel_e       engage_edge;
	} axis_cfg_s;

	typedef struct packed
	{
		logic            psel;
		logic            penable;
		logic            pwrite;
		logic [11:0]     paddr;
		logic [31:0]     pwdata;
	} apb_req_s;

	typedef struct packed
	{
		logic [31:0]     prdata;
		logic            pready;
		logic            pslverr;
	} apb_rsp_s;

endpackage

// ===== src/axis_slip_ramp.sv
`timescale 1ns/1ps
`include "clutch_consts.svh"

module axis_slip_ramp
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  coupled,
	input  wire logic [`SLIP_W-1:0]    engage_slip,
	input  wire logic [`SLIP_W-1:0]    release_slip,
	input  wire logic [`SPEED_W-1:0]   master_speed,
	output logic      [`SPEED_W-1:0]   slave_speed
);
	logic                  coupled_prev_reg;
	logic [`SLIP_W-1:0]    k_reg;
	logic [`SLIP_W-1:0]    den_reg;
	logic [`SPEED_W+`SLIP_W-1:0] scaled;

	// Scale tracks a moving master, so the ramp stays linear in time not in speed
	assign scaled = (master_speed * k_reg) / den_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// Axes come out of reset disabled, hence coupled: follow master at once
			coupled_prev_reg <= 1'b1;
			k_reg            <= 8'h01;
			den_reg          <= 8'h01;
		end
		else
		begin
			coupled_prev_reg <= coupled;
			if (coupled && !coupled_prev_reg)
			begin
				if (engage_slip == 8'h00)
				begin
					den_reg <= 8'h01;
					k_reg   <= 8'h01;
				end
				else
				begin
					den_reg <= engage_slip;
					k_reg   <= 8'h00;
				end
			end
			else if (!coupled && coupled_prev_reg)
			begin
				if (release_slip == 8'h00)
				begin
					den_reg <= 8'h01;
					k_reg   <= 8'h00;
				end
				else
				begin
					den_reg <= release_slip;
					k_reg   <= release_slip;
				end
			end
			else if (coupled && k_reg < den_reg)
				k_reg <= k_reg + 8'h01;
			else if (!coupled && k_reg != 8'h00)
				k_reg <= k_reg - 8'h01;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			slave_speed <= 16'h0000;
		else
			slave_speed <= scaled[`SPEED_W-1:0];
	end

endmodule

// ===== src/clutch_control.sv
`timescale 1ns/1ps
`include "clutch_consts.svh"

module clutch_control
(
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	input  wire clutch_pkg::apb_req_s                 apb_req,
	output clutch_pkg::apb_rsp_s                      apb_rsp,
	input  wire logic [`AXIS_COUNT-1:0]               engage_request,
	input  wire logic [`AXIS_COUNT-1:0]               release_request,
	input  wire logic [`SPEED_W-1:0]                  master_speed,
	input  wire logic [`AXIS_COUNT-1:0][`PHASE_W-1:0] slave_phase,
	output logic      [`AXIS_COUNT-1:0]               coupled_notify,
	output logic      [`AXIS_COUNT-1:0][`SPEED_W-1:0] slave_speed
);
	import clutch_pkg::*;

	logic [`AXIS_COUNT-1:0]               enable_reg;
	logic [`AXIS_COUNT-1:0]               enable_prev_reg;
	axis_cfg_s                            cfg_reg [`AXIS_COUNT];
	axis_state_e                          state_reg [`AXIS_COUNT];
	axis_state_e                          state_next [`AXIS_COUNT];
	logic [`AXIS_COUNT-1:0]               engage_prev_reg;
	logic [`AXIS_COUNT-1:0]               release_prev_reg;
	logic [`AXIS_COUNT-1:0][`PHASE_W-1:0] phase_prev_reg;
	logic [`AXIS_COUNT-1:0]               wait_flag_reg;
	logic [`AXIS_COUNT-1:0]               ramp_coupled;
	logic [`AXIS_COUNT-1:0][`SLIP_W-1:0]  ramp_engage_slip;
	logic [`AXIS_COUNT-1:0][`SLIP_W-1:0]  ramp_release_slip;
	logic                                 access;
	logic                                 commit;
	logic                                 cfg_hit;
	logic [2:0]                           cfg_index;
	logic [31:0]                          read_value;
	logic                                 read_ok;

	function automatic logic edge_hit(input edge_sel_e sel, input logic cur, input logic prev);
		case (sel)
			EDGE_RISE: edge_hit = cur && !prev;
			EDGE_FALL: edge_hit = !cur && prev;
			default:   edge_hit = 1'b0;
		endcase
	endfunction

	// Crossing test, since the phase may skip values between cycles
	function automatic logic phase_reached(input logic [6:0] cur, input logic [6:0] prev,
		input logic [6:0] ratio);
		phase_reached = (cur >= ratio) && ((prev < ratio) || (cur < prev));
	endfunction

	function automatic logic [6:0] clamp_ratio(input logic [6:0] value);
		clamp_ratio = (value > `PHASE_RATIO_MAX) ? `PHASE_RATIO_MAX : value;
	endfunction

	// APB: one wait state, answer in the second access cycle
	assign access    = apb_req.psel && apb_req.penable;
	assign commit    = access && apb_rsp.pready;
	assign cfg_hit   = (apb_req.paddr >= `OFS_AXIS_CFG0) && (apb_req.paddr <= `OFS_AXIS_CFG_LAST)
		&& (apb_req.paddr[1:0] == 2'b00);
	assign cfg_index = apb_req.paddr[4:2];

	always_comb
	begin
		read_value = 32'h0000_0000;
		read_ok    = 1'b1;
		if (apb_req.paddr == `OFS_CTRL)
			read_value[`CTRL_ENABLE_LSB +: `AXIS_COUNT] = enable_reg;
		else if (apb_req.paddr == `OFS_STATUS)
		begin
			read_value[`STATUS_COUPLED_LSB +: `AXIS_COUNT] = coupled_notify;
			read_value[`STATUS_WAIT_LSB +: `AXIS_COUNT]    = wait_flag_reg;
		end
		else if (cfg_hit)
			read_value = cfg_reg[cfg_index];
		else
			read_ok = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			apb_rsp.pready  <= 1'b0;
			apb_rsp.pslverr <= 1'b0;
			apb_rsp.prdata  <= 32'h0000_0000;
		end
		else
		begin
			apb_rsp.pready  <= access && !apb_rsp.pready;
			apb_rsp.pslverr <= access && !apb_rsp.pready && !read_ok;
			// Refused writes clear read data too, so an error never carries stale data
			if (access && !apb_rsp.pready && (!apb_req.pwrite || !read_ok))
				apb_rsp.prdata <= read_value;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			enable_reg <= `CTRL_RESET;
		else if (commit && apb_req.pwrite && apb_req.paddr == `OFS_CTRL)
			enable_reg <= apb_req.pwdata[`CTRL_ENABLE_LSB +: `AXIS_COUNT];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < `AXIS_COUNT; i++)
				cfg_reg[i] <= `AXIS_CFG_RESET;
		end
		else if (commit && apb_req.pwrite && cfg_hit)
		begin
			cfg_reg[cfg_index]             <= apb_req.pwdata;
			cfg_reg[cfg_index].spare       <= 2'b00;
			cfg_reg[cfg_index].phase_ratio <= clamp_ratio(apb_req.pwdata[13:7]);
		end
	end

	// Request history for edge and crossing detection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enable_prev_reg  <= 8'h00;
			engage_prev_reg  <= 8'h00;
			release_prev_reg <= 8'h00;
			phase_prev_reg   <= '0;
		end
		else
		begin
			enable_prev_reg  <= enable_reg;
			engage_prev_reg  <= engage_request;
			release_prev_reg <= release_request;
			phase_prev_reg   <= slave_phase;
		end
	end

	always_comb
	begin
		for (int i = 0; i < `AXIS_COUNT; i++)
		begin
			state_next[i] = state_reg[i];
			if (!enable_reg[i])
				state_next[i] = AXIS_COUPLED;
			else if (!enable_prev_reg[i])
				state_next[i] = AXIS_RELEASED;
			else if (cfg_reg[i].engage_edge == EDGE_LEVEL)
				state_next[i] = engage_request[i] ? AXIS_COUPLED : AXIS_RELEASED;
			else
			begin
				case (state_reg[i])
					AXIS_RELEASED:
					begin
						if (edge_hit(cfg_reg[i].engage_edge, engage_request[i], engage_prev_reg[i]))
							state_next[i] = AXIS_COUPLED;
					end
					AXIS_COUPLED:
					begin
						if (edge_hit(cfg_reg[i].release_edge, release_request[i], release_prev_reg[i]))
						begin
							if (cfg_reg[i].release_phase_sel)
								state_next[i] = AXIS_PHASE_WAIT;
							else
								state_next[i] = AXIS_RELEASED;
						end
					end
					AXIS_PHASE_WAIT:
					begin
						// Entered only on the trigger, so a phase already past waits for the next wrap
						if (phase_reached(slave_phase[i], phase_prev_reg[i], cfg_reg[i].phase_ratio))
							state_next[i] = AXIS_RELEASED;
					end
					default:
						state_next[i] = AXIS_RELEASED;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < `AXIS_COUNT; i++)
				state_reg[i] <= AXIS_COUPLED;
			coupled_notify <= 8'hFF;
			wait_flag_reg  <= 8'h00;
		end
		else
		begin
			for (int i = 0; i < `AXIS_COUNT; i++)
			begin
				state_reg[i]      <= state_next[i];
				coupled_notify[i] <= (state_next[i] != AXIS_RELEASED);
				wait_flag_reg[i]  <= (state_next[i] == AXIS_PHASE_WAIT);
			end
		end
	end

	// Slave keeps following during phase wait, so ramps see the notify level
	always_comb
	begin
		for (int i = 0; i < `AXIS_COUNT; i++)
		begin
			ramp_coupled[i] = coupled_notify[i];
			ramp_engage_slip[i] = (enable_reg[i] && cfg_reg[i].engage_slip_sel) ? cfg_reg[i].engage_slip : 8'h00;
			ramp_release_slip[i] = (enable_reg[i] && cfg_reg[i].release_slip_sel) ? cfg_reg[i].release_slip : 8'h00;
		end
	end

	for (genvar g = 0; g < `AXIS_COUNT; g++)
	begin : g_axis
		axis_slip_ramp u_ramp
		(
			.pclk         (pclk),
			.presetn      (presetn),
			.coupled      (ramp_coupled[g]),
			.engage_slip  (ramp_engage_slip[g]),
			.release_slip (ramp_release_slip[g]),
			.master_speed (master_speed),
			.slave_speed  (slave_speed[g])
		);
	end

endmodule

// ===== test/clutch_control_asserts.sv
`timescale 1ns/1ps
`include "clutch_consts.svh"

module clutch_control_asserts
(
	input wire logic                                 pclk,
	input wire logic                                 presetn,
	input wire clutch_pkg::apb_req_s                 apb_req,
	input wire clutch_pkg::apb_rsp_s                 apb_rsp,
	input wire logic [`AXIS_COUNT-1:0]               engage_request,
	input wire logic [`AXIS_COUNT-1:0]               release_request,
	input wire logic [`SPEED_W-1:0]                  master_speed,
	input wire logic [`AXIS_COUNT-1:0][`PHASE_W-1:0] slave_phase,
	input wire logic [`AXIS_COUNT-1:0]               coupled_notify,
	input wire logic [`AXIS_COUNT-1:0][`SPEED_W-1:0] slave_speed
);
	import clutch_pkg::*;
	logic over;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Neither ramp direction may overshoot a steady master
	always_comb
	begin
		over = 1'b0;
		for (int i = 0; i < `AXIS_COUNT; i++)
			if (slave_speed[i] > master_speed)
				over = 1'b1;
	end
	ready_cause_a: assert property (apb_rsp.pready |-> $past(apb_req.psel && apb_req.penable))
		else $error("pready without access");
	one_wait_a: assert property (apb_req.psel && apb_req.penable && !$past(apb_req.penable)
		|-> !apb_rsp.pready ##1 apb_rsp.pready) else $error("access wait wrong");
	ready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready) else $error("pready too long");
	setup_idle_a: assert property (apb_req.psel && !apb_req.penable |-> !apb_rsp.pready)
		else $error("pready in setup");
	err_zero_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready && apb_rsp.prdata == 32'h0)
		else $error("error response wrong");
	reset_coupled_a: assert property ($rose(presetn) |-> &coupled_notify)
		else $error("notify not coupled after reset");
	notify_cause_a: assert property ($past(engage_request) == $past(engage_request, 2)
		&& $past(release_request) == $past(release_request, 2) && $past(slave_phase) == $past(slave_phase, 2)
		&& !$past(apb_req.psel) && !$past(apb_req.psel, 2) |-> $stable(coupled_notify))
		else $error("notify changed without cause");
	speed_bound_a: assert property ($stable(master_speed) && $past(master_speed) == $past(master_speed, 2)
		|-> !over) else $error("slave speed above master");
endmodule

// ===== test/host_io_model.sv
`timescale 1ns/1ps

module host_io_model
#(
	parameter logic [15:0] MASTER = 16'h1234
)
(
	input wire logic        pclk,
	output logic [7:0]      engage_request,
	output logic [7:0]      release_request,
	output logic [15:0]     master_speed,
	output logic [7:0][6:0] slave_phase
);
	initial
	begin
		engage_request = 8'h00;
		release_request = 8'h00;
		slave_phase = '0;
		master_speed = MASTER;
	end
	// Kind 0 engage, 1 release, else phase; held two cycles
	task drive(input int kind, input int ax, input logic [6:0] v);
		@(posedge pclk);
		case (kind)
			0: engage_request[ax] <= v[0];
			1: release_request[ax] <= v[0];
			default: slave_phase[ax] <= v;
		endcase
		repeat (2) @(posedge pclk);
	endtask
endmodule

// ===== test/clutch_control_tb.sv
`timescale 1ns/1ps

module clutch_control_tb;
	import clutch_pkg::*;
	localparam logic [15:0] MSPD = 16'h1234;
	logic              pclk;
	logic              presetn;
	apb_req_s          req;
	apb_rsp_s          rsp;
	logic [7:0]        eng;
	logic [7:0]        rel;
	logic [7:0]        notify;
	logic [15:0]       mspd;
	logic [7:0][6:0]   ph;
	logic [7:0][15:0]  spd;
	logic [31:0]       rd;
	logic              err;
	int                n_mismatch;
	int                num_checks;
	logic [31:0]       cfg [5] = '{32'h0, 32'h11, 32'h22, 32'h1919, 32'h40005};

	clutch_control clutch_control_inst (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.engage_request(eng), .release_request(rel), .master_speed(mspd), .slave_phase(ph),
		.coupled_notify(notify), .slave_speed(spd));
	host_io_model #(.MASTER(MSPD)) host_io_model_inst (.pclk(pclk), .engage_request(eng),
		.release_request(rel), .master_speed(mspd), .slave_phase(ph));

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge pclk);
		req.penable <= 1'b1;
		@(posedge pclk);
		while (rsp.pready !== 1'b1)
			@(posedge pclk);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task st(input int kind, input int ax, input logic [6:0] v, input logic e);
		host_io_model_inst.drive(kind, ax, v);
		chk("notify", {31'h0, e}, {31'h0, notify[ax]});
	endtask

	task summarize;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial
	begin
		repeat (4000) @(posedge pclk);
		n_mismatch++;
		summarize();
	end

	initial
	begin
		req = '0;
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl", 32'h0, rd);
		chk("notify", 32'hFF, {24'h0, notify});
		apb(1'b0, 12'h004, 32'h0);
		chk("status", 32'hFF, rd & 32'hFF);
		apb(1'b1, 12'h034, 32'h3F80);
		apb(1'b0, 12'h034, 32'h0);
		chk("ratio", 32'h3180, rd);
		apb(1'b1, 12'h008, 32'hFFFF_FFFF);
		chk("wrerr", 32'h1, {31'h0, err});
		chk("wrdata", 32'h0, rd);
		apb(1'b0, 12'h100, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		chk("rdata", 32'h0, rd);
		$display("test registers done");
		for (int i = 0; i < 5; i++)
			apb(1'b1, 12'(32 + 4 * i), cfg[i]);
		apb(1'b1, 12'h000, 32'h1F);
		repeat (3) @(posedge pclk);
		chk("notify", 32'hE0, {24'h0, notify});
		st(0, 0, 7'h1, 1'b1);
		st(1, 0, 7'h1, 1'b1);
		st(1, 0, 7'h0, 1'b1);
		st(0, 0, 7'h0, 1'b0);
		st(0, 1, 7'h1, 1'b1);
		repeat (2) @(posedge pclk);
		chk("speed", {16'h0, MSPD}, {16'h0, spd[1]});
		st(1, 1, 7'h1, 1'b0);
		repeat (2) @(posedge pclk);
		chk("speed", 32'h0, {16'h0, spd[1]});
		st(0, 2, 7'h1, 1'b0);
		st(0, 2, 7'h0, 1'b1);
		st(1, 2, 7'h1, 1'b1);
		st(1, 2, 7'h0, 1'b0);
		$display("test edges done");
		st(0, 3, 7'h1, 1'b1);
		st(2, 3, 7'd60, 1'b1);
		st(1, 3, 7'h1, 1'b1);
		apb(1'b0, 12'h004, 32'h0);
		chk("status", 32'h0808, rd & 32'h0808);
		st(2, 3, 7'd10, 1'b1);
		st(2, 3, 7'd50, 1'b0);
		st(0, 4, 7'h1, 1'b1);
		chk("ramp", 32'h1, {31'h0, spd[4] !== MSPD});
		repeat (8) @(posedge pclk);
		chk("speed", {16'h0, MSPD}, {16'h0, spd[4]});
		st(1, 4, 7'h1, 1'b1);
		apb(1'b1, 12'h030, 32'h0404_0055);
		st(1, 4, 7'h0, 1'b1);
		st(1, 4, 7'h1, 1'b0);
		chk("ramp", 32'h1, {31'h0, spd[4] !== 16'h0000});
		repeat (8) @(posedge pclk);
		chk("speed", 32'h0, {16'h0, spd[4]});
		st(0, 5, 7'h1, 1'b1);
		st(1, 5, 7'h1, 1'b1);
		chk("speed", {16'h0, MSPD}, {16'h0, spd[5]});
		$display("test phase and slip done");
		summarize();
	end
endmodule

bind clutch_control clutch_control_asserts clutch_control_asserts_inst (.pclk(pclk), .presetn(presetn),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .engage_request(engage_request), .release_request(release_request),
	.master_speed(master_speed), .slave_phase(slave_phase), .coupled_notify(coupled_notify),
	.slave_speed(slave_speed));
